// ### ctrl_device_model.sv
// Model of the external control device that drives the pins and reads the tach
`timescale 1ns/1ps
module ctrl_device_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic brake_i,
    input wire logic cw_i,
    input wire logic onboard_i,
    input wire logic clr_i,
    input wire logic tach_i,
    output logic [4:0] din_n_o,
    output int tach_cnt_o,
    output int tach_w_o
);
    int w;

    initial
    begin
        din_n_o = 5'h1f;
        tach_cnt_o = 0;
        tach_w_o = 0;
        w = 0;
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Asserted commands leave as low levels; clear is raised then dropped by the bench
    always @(posedge clk_i)
    begin
        din_n_o <= ~{clr_i, onboard_i, cw_i, brake_i, run_i};
    end

    // ------------------------------------------------------------
    // Tach capture
    // ------------------------------------------------------------
    // Width in clocks, logged when the pulse ends
    always @(posedge clk_i)
    begin
        if (tach_i === 1'b1)
            w = w + 1;
        else if (w != 0)
        begin
            tach_w_o <= w;
            tach_cnt_o <= tach_cnt_o + 1;
            w = 0;
        end
    end
endmodule

// ### input_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk_i)
            begin
                if (!nrst_i)
                begin
                    meta_q[i] <= INIT[i];
                    q_o[i] <= INIT[i];
                end
                else
                begin
                    meta_q[i] <= d_i[i];
                    q_o[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule

// ### motor_drive_io_control.sv
// Control-signal logic of the brushless motor drive
`timescale 1ns/1ps
module motor_drive_io_control #(
    parameter int TACH_WIDTH_CYC = motor_pkg::TACH_WIDTH_CYC,
    parameter int BLINK_HALF_CYC = motor_pkg::BLINK_HALF_CYC,
    parameter int RAMP_UNIT_CYC = motor_pkg::RAMP_UNIT_CYC
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [4:0] DIGITAL_IN_N_I,
    input wire logic [7:0] ONBOARD_SPEED_POT_I,
    input wire logic [7:0] EXT_SPEED_I,
    input wire logic [7:0] RAMP_TIME_POT_I,
    input wire logic HALL_EDGE_I,
    input wire logic [2:0] FAULT_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    output logic IRQ_O,
    output logic [7:0] MOTOR_SPEED_O,
    output logic MOTOR_EN_O,
    output logic MOTOR_DIR_CW_O,
    output logic DIGITAL_OUT_0_O,
    output logic DIGITAL_OUT_1_O,
    output logic LED_GREEN_O,
    output logic LED_RED_O
);
    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    logic [4:0] din_s;
    logic [2:0] fault_s;
    logic hall_s;
    motor_pkg::ctl_in_t act;

    input_sync #(.W(9), .INIT(9'h1f)) u_sync (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .d_i({HALL_EDGE_I, FAULT_I, DIGITAL_IN_N_I}),
        .q_o({hall_s, fault_s, din_s})
    );

    assign act = ~din_s;

    // ----------------------------------------------------------------
    // Alarm
    // ----------------------------------------------------------------
    function automatic logic [2:0] alarm_code(input logic [2:0] f, input logic inj);
        alarm_code = 3'h0;
        if (inj)
            alarm_code = 3'h1;
        for (int k = motor_pkg::NUM_FAULTS - 1; k >= 0; k--)
            if (f[k])
                alarm_code = 3'(k + 2);
    endfunction

    logic [1:0] ctrl_q;
    logic alarm_q;
    logic [2:0] code_q;
    logic clr_prev_q;
    logic clr_release;
    logic [2:0] new_code;

    assign new_code = alarm_code(fault_s, ctrl_q[motor_pkg::CTRL_ALARM_INJ_BIT]);
    assign clr_release = clr_prev_q && !act.alarm_clear;

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            alarm_q <= 1'b0;
            code_q <= 3'h0;
            clr_prev_q <= 1'b0;
        end
        else
        begin
            clr_prev_q <= act.alarm_clear;
            if (new_code != 3'h0 && !alarm_q)
            begin
                alarm_q <= 1'b1;
                code_q <= new_code;
            end
            else if (alarm_q && clr_release && new_code == 3'h0)
            begin
                alarm_q <= 1'b0;
                code_q <= 3'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Speed setpoint and ramp
    // ----------------------------------------------------------------
    logic [7:0] setpoint_q;
    logic [15:0] unit_cnt_q;
    logic [7:0] ramp_cnt_q;
    logic ramp_tick;
    motor_pkg::motion_t state_q;

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            setpoint_q <= 8'h00;
        else
            setpoint_q <= act.speed_source_select ? ONBOARD_SPEED_POT_I : EXT_SPEED_I;
    end

    // Ramp time scales with the pot: one speed step per (pot+1) units
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            unit_cnt_q <= 16'h0000;
            ramp_cnt_q <= 8'h00;
        end
        else if (unit_cnt_q == 16'(RAMP_UNIT_CYC - 1))
        begin
            unit_cnt_q <= 16'h0000;
            ramp_cnt_q <= (ramp_cnt_q >= RAMP_TIME_POT_I) ? 8'h00 : ramp_cnt_q + 8'h01;
        end
        else
            unit_cnt_q <= unit_cnt_q + 16'h0001;
    end

    assign ramp_tick = (unit_cnt_q == 16'(RAMP_UNIT_CYC - 1)) && (ramp_cnt_q >= RAMP_TIME_POT_I);

    // ----------------------------------------------------------------
    // Motion control
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            state_q <= motor_pkg::ST_STOP;
            MOTOR_SPEED_O <= 8'h00;
            MOTOR_EN_O <= 1'b0;
        end
        else if (!act.brake_release || alarm_q)
        begin
            state_q <= motor_pkg::ST_STOP;
            MOTOR_SPEED_O <= 8'h00;
            MOTOR_EN_O <= 1'b0;
        end
        else
        begin
            case (state_q)
                motor_pkg::ST_STOP:
                begin
                    if (act.run_request)
                    begin
                        state_q <= motor_pkg::ST_RUN;
                        MOTOR_EN_O <= 1'b1;
                    end
                end
                motor_pkg::ST_RUN:
                begin
                    if (!act.run_request)
                        state_q <= motor_pkg::ST_DECEL;
                    else if (ramp_tick && MOTOR_SPEED_O < setpoint_q)
                        MOTOR_SPEED_O <= MOTOR_SPEED_O + 8'h01;
                    else if (ramp_tick && MOTOR_SPEED_O > setpoint_q)
                        MOTOR_SPEED_O <= MOTOR_SPEED_O - 8'h01;
                end
                motor_pkg::ST_DECEL:
                begin
                    // A new run request during the ramp down resumes at the current speed
                    if (act.run_request)
                        state_q <= motor_pkg::ST_RUN;
                    else if (MOTOR_SPEED_O == 8'h00)
                    begin
                        state_q <= motor_pkg::ST_STOP;
                        MOTOR_EN_O <= 1'b0;
                    end
                    else if (ramp_tick)
                        MOTOR_SPEED_O <= MOTOR_SPEED_O - 8'h01;
                end
                default:
                begin
                    state_q <= motor_pkg::ST_STOP;
                    MOTOR_SPEED_O <= 8'h00;
                    MOTOR_EN_O <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            MOTOR_DIR_CW_O <= 1'b0;
        else
            MOTOR_DIR_CW_O <= act.direction_select;
    end

    // ----------------------------------------------------------------
    // Tachometer
    // ----------------------------------------------------------------
    logic hall_prev_q;
    logic hall_evt;
    logic [1:0] edge_cnt_q;
    logic [15:0] tach_cnt_q;
    logic tach_fire;

    assign hall_evt = hall_s != hall_prev_q;
    assign tach_fire = hall_evt && edge_cnt_q == 2'(motor_pkg::EDGES_PER_TACH - 1);

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            hall_prev_q <= 1'b0;
            edge_cnt_q <= 2'h0;
        end
        else
        begin
            hall_prev_q <= hall_s;
            if (hall_evt)
                edge_cnt_q <= tach_fire ? 2'h0 : edge_cnt_q + 2'h1;
        end
    end

    // Fixed width; above the speed where pulses would overlap, a fire is dropped
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            DIGITAL_OUT_0_O <= 1'b0;
            tach_cnt_q <= 16'h0000;
        end
        else if (DIGITAL_OUT_0_O)
        begin
            if (tach_cnt_q == 16'h0000)
                DIGITAL_OUT_0_O <= 1'b0;
            else
                tach_cnt_q <= tach_cnt_q - 16'h0001;
        end
        else if (tach_fire && ctrl_q[motor_pkg::CTRL_TACH_EN_BIT])
        begin
            DIGITAL_OUT_0_O <= 1'b1;
            tach_cnt_q <= 16'(TACH_WIDTH_CYC - 1);
        end
    end

    // ----------------------------------------------------------------
    // Alarm output and LED
    // ----------------------------------------------------------------
    logic [25:0] blink_cnt_q;
    logic [4:0] blink_step_q;
    logic blink_tick;

    assign blink_tick = blink_cnt_q == 26'(BLINK_HALF_CYC - 1);

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I || !alarm_q)
        begin
            blink_cnt_q <= 26'h0000000;
            blink_step_q <= 5'h00;
        end
        else if (blink_tick)
        begin
            blink_cnt_q <= 26'h0000000;
            if (blink_step_q == 5'({code_q, 1'b0}) + 5'(motor_pkg::BLINK_PAUSE_STEPS) - 5'h01)
                blink_step_q <= 5'h00;
            else
                blink_step_q <= blink_step_q + 5'h01;
        end
        else
            blink_cnt_q <= blink_cnt_q + 26'h0000001;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            DIGITAL_OUT_1_O <= 1'b1;
            LED_GREEN_O <= 1'b1;
            LED_RED_O <= 1'b0;
        end
        else
        begin
            DIGITAL_OUT_1_O <= !alarm_q;
            LED_GREEN_O <= !alarm_q;
            LED_RED_O <= alarm_q && !blink_step_q[0] &&
                blink_step_q < 5'({code_q, 1'b0});
        end
    end

    // ----------------------------------------------------------------
    // Registers and interrupt
    // ----------------------------------------------------------------
    logic [2:0] int_stat_q;
    logic [2:0] int_mask_q;
    logic [2:0] int_evt;
    logic en_prev_q;

    assign int_evt = {en_prev_q && !MOTOR_EN_O, !en_prev_q && MOTOR_EN_O,
        new_code != 3'h0 && !alarm_q};

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            ctrl_q <= motor_pkg::CTRL_RESET;
            int_mask_q <= motor_pkg::INT_MASK_RESET;
        end
        else if (WR_I && ADDR_I == motor_pkg::OFS_CTRL)
            ctrl_q <= WDATA_I[1:0];
        else if (WR_I && ADDR_I == motor_pkg::OFS_INT_MASK)
            int_mask_q <= WDATA_I[2:0];
    end

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            int_stat_q <= 3'h0;
            en_prev_q <= 1'b0;
            IRQ_O <= 1'b0;
        end
        else
        begin
            en_prev_q <= MOTOR_EN_O;
            int_stat_q <= (int_stat_q & ~((WR_I && ADDR_I == motor_pkg::OFS_INT_STAT) ?
                WDATA_I[2:0] : 3'h0)) | int_evt;
            IRQ_O <= |(int_stat_q & int_mask_q);
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            RDATA_O <= 32'h00000000;
        else if (RD_I)
        begin
            case (ADDR_I)
                motor_pkg::OFS_CTRL: RDATA_O <= {30'h0, ctrl_q};
                motor_pkg::OFS_STATUS: RDATA_O <= {16'h0, MOTOR_SPEED_O, 1'b0, code_q,
                    alarm_q, MOTOR_DIR_CW_O, state_q};
                motor_pkg::OFS_INT_STAT: RDATA_O <= {29'h0, int_stat_q};
                motor_pkg::OFS_INT_MASK: RDATA_O <= {29'h0, int_mask_q};
                default: RDATA_O <= 32'h00000000;
            endcase
        end
        else
            RDATA_O <= 32'h00000000;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence brake_drop_s;
        !act.brake_release;
    endsequence

    start_gate_a: assert property ($rose(MOTOR_EN_O) |-> $past(act.run_request && act.brake_release))
        else $error("motor enabled without run and brake release");
    decel_down_a: assert property (state_q == motor_pkg::ST_DECEL && act.brake_release && !alarm_q
        |=> MOTOR_SPEED_O <= $past(MOTOR_SPEED_O))
        else $error("speed rose while ramping down");
    brake_stop_a: assert property (brake_drop_s |=> MOTOR_SPEED_O == 8'h00 && !MOTOR_EN_O)
        else $error("brake drop did not stop motor at once");
    dir_follow_a: assert property (##1 MOTOR_DIR_CW_O == !$past(din_s[2]))
        else $error("direction does not follow input");
    src_select_a: assert property ($past(NRST_I) |-> setpoint_q ==
        ($past(act.speed_source_select) ? $past(ONBOARD_SPEED_POT_I) : $past(EXT_SPEED_I)))
        else $error("wrong speed source");
    alarm_clear_a: assert property (alarm_q && clr_release && new_code == 3'h0 |=> !alarm_q)
        else $error("alarm not cleared on release");
    tach_start_a: assert property ($rose(DIGITAL_OUT_0_O) |-> $past(tach_fire) &&
        tach_cnt_q == 16'(TACH_WIDTH_CYC - 1))
        else $error("tach pulse not tied to rotation");
    tach_width_a: assert property (DIGITAL_OUT_0_O && tach_cnt_q != 16'h0000 |=> DIGITAL_OUT_0_O)
        else $error("tach pulse ended early");
    alarm_out_a: assert property (alarm_q |=> !DIGITAL_OUT_1_O ##0 !LED_GREEN_O)
        else $error("alarm output still on during alarm");
    polarity_a: assert property ($past(DIGITAL_IN_N_I[0], 2) |-> !act.run_request)
        else $error("high level treated as asserted");
    blink_count_a: assert property (LED_RED_O |-> $past(blink_step_q) < $past(5'({code_q, 1'b0})))
        else $error("red blink beyond alarm code");
    alarm_hold_a: assert property (alarm_q |=> !MOTOR_EN_O && MOTOR_SPEED_O == 8'h00)
        else $error("motor ran during alarm");
endmodule

// ### motor_drive_io_control_test.sv
// Self-checking bench for the motor drive control logic
`timescale 1ns/1ps
module motor_drive_io_control_test;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    // Short counts keep the run small; expectations follow them
    localparam int TW = 8;
    localparam int BH = 4;
    localparam int RU = 2;
    typedef struct {
        logic cw;
        logic onb;
        logic [7:0] spd;
    } row_t;
    row_t rows [4] = '{'{1'b1, 1'b1, 8'h05}, '{1'b1, 1'b0, 8'h09},
                       '{1'b0, 1'b1, 8'h05}, '{1'b0, 1'b0, 8'h09}};
    logic clk, nrst, hall, wr, rd, irq, en, dir_cw, tach, alm_n, green, red;
    logic run, brake, cw, onb, clr;
    logic [4:0] din_n;
    logic [7:0] pot, ext, ramp, speed;
    logic [2:0] fault;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, r;
    int mismatches, checked, n, c, tach_cnt, tach_w;

    ctrl_device_model dev (.clk_i(clk), .run_i(run), .brake_i(brake), .cw_i(cw),
        .onboard_i(onb), .clr_i(clr), .tach_i(tach), .din_n_o(din_n),
        .tach_cnt_o(tach_cnt), .tach_w_o(tach_w));

    motor_drive_io_control #(.TACH_WIDTH_CYC(TW), .BLINK_HALF_CYC(BH), .RAMP_UNIT_CYC(RU)) dut (
        .CLK_I(clk), .NRST_I(nrst), .DIGITAL_IN_N_I(din_n), .ONBOARD_SPEED_POT_I(pot),
        .EXT_SPEED_I(ext), .RAMP_TIME_POT_I(ramp), .HALL_EDGE_I(hall), .FAULT_I(fault),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq),
        .MOTOR_SPEED_O(speed), .MOTOR_EN_O(en), .MOTOR_DIR_CW_O(dir_cw),
        .DIGITAL_OUT_0_O(tach), .DIGITAL_OUT_1_O(alm_n), .LED_GREEN_O(green), .LED_RED_O(red));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task chk1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Values read at an edge are those settled before it
    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task wrw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rdw(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    // Bounded wait, then the speed itself is compared
    task wait_speed(input logic [7:0] exp);
        for (int i = 0; i < 400 && speed !== exp; i++)
            @(posedge clk);
        chk("speed", {24'h0, exp}, {24'h0, speed});
    endtask

    // Any window of whole blink periods holds a fixed number of rises
    task count_red(input int k, output int cnt);
        logic p;
        p = red;
        cnt = 0;
        repeat (k)
        begin
            @(posedge clk);
            if (red === 1'b1 && p !== 1'b1)
                cnt++;
            p = red;
        end
    endtask

    task clear_alarm;
        clr <= 1'b1;
        cyc(6);
        chk1("alarm kept while clear held", 1'b0, alm_n);
        clr <= 1'b0;
        cyc(8);
        chk1("alarm cleared on release", 1'b1, alm_n);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize;
    end

    initial
    begin
        {nrst, hall, wr, rd, run, brake, cw, onb, clr} = '0;
        addr = 4'h0;
        wdata = 32'h0;
        pot = 8'h05;
        ext = 8'h09;
        ramp = 8'h00;
        fault = 3'h0;
        mismatches = 0;
        checked = 0;
        cyc(20);
        nrst <= 1'b1;
        cyc(2);
        chk1("alarm out", 1'b1, alm_n);
        chk1("enable", 1'b0, en);
        chk1("green", 1'b1, green);
        chk1("red", 1'b0, red);
        rdw(motor_pkg::OFS_CTRL, r);
        chk("ctrl", 32'(motor_pkg::CTRL_RESET), r);
        rdw(motor_pkg::OFS_INT_MASK, r);
        chk("mask", 32'(motor_pkg::INT_MASK_RESET), r);
        rdw(4'h2, r);
        chk("unmapped", 32'h0, r);
        run <= 1'b1;
        cyc(10);
        chk1("enable without brake", 1'b0, en);
        brake <= 1'b1;
        foreach (rows[i])
        begin
            cw <= rows[i].cw;
            onb <= rows[i].onb;
            cyc(1);
            wait_speed(rows[i].spd);
            chk1("enable", 1'b1, en);
            chk1("direction", rows[i].cw, dir_cw);
        end
        ramp <= 8'h03;
        run <= 1'b0;
        cyc(12);
        chk1("enable while ramping", 1'b1, en);
        chk1("speed not dropped", 1'b1, speed != 8'h00);
        wait_speed(8'h00);
        cyc(3);
        chk1("enable after ramp", 1'b0, en);
        ramp <= 8'h00;
        run <= 1'b1;
        cyc(1);
        wait_speed(8'h09);
        brake <= 1'b0;
        cyc(6);
        chk("speed at brake", 32'h0, {24'h0, speed});
        chk1("enable at brake", 1'b0, en);
        brake <= 1'b1;
        n = tach_cnt;
        // Hall toggles spaced wider than a pulse so none is dropped
        repeat (60)
        begin
            cyc(12);
            hall <= ~hall;
        end
        cyc(20);
        chk("tach count", 32'd30, 32'(tach_cnt - n));
        chk("tach width", 32'(TW), 32'(tach_w));
        // Tach enable cleared: rotation goes on but no pulse may leave
        wrw(motor_pkg::OFS_CTRL, 32'h0);
        n = tach_cnt;
        repeat (4)
        begin
            cyc(12);
            hall <= ~hall;
        end
        cyc(20);
        chk("tach disabled", 32'd0, 32'(tach_cnt - n));
        wrw(motor_pkg::OFS_CTRL, 32'h1);
        wrw(motor_pkg::OFS_INT_STAT, 32'h7);
        wrw(motor_pkg::OFS_INT_MASK, 32'h1);
        fault <= 3'h1;
        cyc(8);
        chk1("alarm out on fault", 1'b0, alm_n);
        chk1("enable in alarm", 1'b0, en);
        chk1("irq", 1'b1, irq);
        rdw(motor_pkg::OFS_INT_STAT, r);
        chk1("alarm event", 1'b1, r[motor_pkg::INT_ALARM_BIT]);
        rdw(motor_pkg::OFS_STATUS, r);
        chk("status in alarm", 32'h00000028, r);
        count_red(96, c);
        chk("blinks fault", 32'd6, 32'(c));
        chk1("green in alarm", 1'b0, green);
        fault <= 3'h0;
        cyc(8);
        chk1("alarm kept without clear", 1'b0, alm_n);
        clear_alarm;
        wrw(motor_pkg::OFS_INT_STAT, 32'h1);
        cyc(3);
        chk1("irq cleared", 1'b0, irq);
        wrw(motor_pkg::OFS_INT_MASK, 32'h0);
        wrw(motor_pkg::OFS_CTRL, 32'h3);
        cyc(6);
        chk1("alarm out on inject", 1'b0, alm_n);
        chk1("irq masked", 1'b0, irq);
        count_red(96, c);
        chk("blinks inject", 32'd4, 32'(c));
        rdw(motor_pkg::OFS_INT_STAT, r);
        chk1("masked event", 1'b1, r[motor_pkg::INT_ALARM_BIT]);
        wrw(motor_pkg::OFS_CTRL, 32'h1);
        clear_alarm;
        // Reset in mid-run while the motor turns
        nrst <= 1'b0;
        cyc(3);
        chk("speed in reset", 32'h0, {24'h0, speed});
        chk1("enable in reset", 1'b0, en);
        chk1("alarm out in reset", 1'b1, alm_n);
        chk1("irq in reset", 1'b0, irq);
        nrst <= 1'b1;
        cyc(2);
        chk1("enable before pins settle", 1'b0, en);
        cyc(8);
        chk1("restart after reset", 1'b1, en);
        summarize;
    end
endmodule

// ### motor_pkg.sv
// Shared constants and types for the motor drive control logic
package motor_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TACH_PULSE_NS = 300000;
    localparam int TACH_WIDTH_CYC = TACH_PULSE_NS / CLK_PERIOD_NS;
    localparam int BLINK_HALF_NS = 250000000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam int RAMP_UNIT_NS = 100000;
    localparam int RAMP_UNIT_CYC = RAMP_UNIT_NS / CLK_PERIOD_NS;
    localparam int BLINK_PAUSE_STEPS = 4;

    // ----------------------------------------------------------------
    // Rotation feedback
    // ----------------------------------------------------------------
    localparam int HALL_EDGES_PER_REV = 60;
    localparam int TACH_PER_REV = 30;
    localparam int EDGES_PER_TACH = HALL_EDGES_PER_REV / TACH_PER_REV;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_INT_STAT = 4'h8;
    localparam logic [3:0] OFS_INT_MASK = 4'hc;
    localparam int CTRL_TACH_EN_BIT = 0;
    localparam int CTRL_ALARM_INJ_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int INT_ALARM_BIT = 0;
    localparam int INT_START_BIT = 1;
    localparam int INT_STOP_BIT = 2;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;
    localparam int NUM_FAULTS = 3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic alarm_clear;
        logic speed_source_select;
        logic direction_select;
        logic brake_release;
        logic run_request;
    } ctl_in_t;

    typedef enum logic [1:0] {
        ST_STOP = 2'b00,
        ST_RUN = 2'b01,
        ST_DECEL = 2'b10
    } motion_t;

endpackage
